//--- common/ddc_pkg.sv
package ddc_pkg;
    // ==================================================
    // Register offsets
    localparam logic [5:0]  ADDR_PD     = 6'h1d;
    localparam logic [5:0]  ADDR_CLK    = 6'h1e;
    localparam logic [5:0]  ADDR_MODE   = 6'h1f;
    localparam logic [5:0]  ADDR_FILT   = 6'h20;
    localparam logic [5:0]  ADDR_AUX_HI = 6'h26;
    localparam logic [5:0]  ADDR_AUX_LO = 6'h27;
    // ==================================================
    // Field positions and writable masks
    localparam int          PD_QDAC_BIT   = 2;
    localparam int          CLK_BYP_BIT   = 5;
    localparam int          CLK_RANGE_BIT = 6;
    localparam int          MODE_LSB      = 1;
    localparam int          MODE_SRC_BIT  = 4;
    localparam int          FILT_SDO_BIT  = 0;
    localparam int          FILT_LSBF_BIT = 1;
    localparam int          FILT_SINC_BIT = 6;
    localparam logic [7:0]  PD_MASK   = 8'h04;
    localparam logic [7:0]  CLK_MASK  = 8'h7f;
    localparam logic [7:0]  MODE_MASK = 8'h1e;
    localparam logic [7:0]  FILT_MASK = 8'h43;
    // ==================================================
    // Values after reset, and ratio clamp limits
    localparam logic [7:0]  RST_PD   = 8'h00;
    localparam logic [7:0]  RST_CLK  = 8'h04;
    localparam logic [7:0]  RST_MODE = 8'h00;
    localparam logic [7:0]  RST_FILT = 8'h00;
    localparam logic [11:0] RST_AUX  = 12'h000;
    localparam logic [4:0]  MULT_MIN = 5'h04;
    localparam logic [4:0]  MULT_MAX = 5'h14;
    // ==================================================
    // Pin synchroniser layout, and last serial bit count
    localparam int          SYNC_W      = 22;
    localparam int          SY_UPD      = 0;
    localparam int          SY_DIFF     = 1;
    localparam int          SY_PSEL     = 2;
    localparam int          SY_SDIO     = 3;
    localparam int          SY_CS       = 4;
    localparam int          SY_SCLK     = 5;
    localparam int          SY_RD       = 6;
    localparam int          SY_WR       = 7;
    localparam int          SY_DATA     = 8;
    localparam int          SY_ADDR     = 16;
    localparam logic [21:0] SYNC_RST    = 22'h0000d0;
    localparam logic [2:0]  BIT_LAST    = 3'h7;
    // ==================================================
    // Types
    typedef enum logic [2:0] {
        DDC_SINGLE = 3'h0,
        DDC_FSK    = 3'h1,
        DDC_RAMP   = 3'h2,
        DDC_CHIRP  = 3'h3,
        DDC_BPSK   = 3'h4
    } ddc_mode_t;

    typedef enum logic [2:0] {
        SER_IDLE  = 3'b001,
        SER_INSTR = 3'b010,
        SER_DATA  = 3'b100
    } ddc_ser_st_t;
endpackage : ddc_pkg

//--- common/ddc_cfg_if.sv
`timescale 1ns/10ps
interface ddc_cfg_if;
    logic        q_pd;
    logic        pll_range;
    logic        pll_bypass;
    logic [4:0]  mult;
    logic [2:0]  mode_code;
    logic        aux_src;
    logic        sinc_byp;
    logic [11:0] aux_data;

    modport drv  (output q_pd, pll_range, pll_bypass, mult, mode_code, aux_src, sinc_byp,
                  aux_data);
    modport core (input q_pd, pll_range, pll_bypass, mult, mode_code, aux_src, sinc_byp,
                  aux_data);
endinterface : ddc_cfg_if

//--- src/ddc_core.sv
`timescale 1ns/10ps
module ddc_core
    import ddc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    ddc_cfg_if.core          cfg,
    input  wire logic [11:0] q_path_data_i,
    output logic      [11:0] q_dac_data_o,
    output logic             q_dac_pd_o,
    output logic             i_sinc_bypass_o,
    output logic             q_sinc_bypass_o,
    output logic      [4:0]  ref_mult_o,
    output logic             pll_range_o,
    output logic             sysclk_from_ref_o,
    output logic      [2:0]  mode_o
);
    typedef struct packed {
        ddc_mode_t   mode;
        logic [4:0]  mult;
        logic [11:0] qd;
        logic        pd;
        logic        isb;
        logic        qsb;
        logic        range;
        logic        byp;
    } ddc_core_st_t;

    ddc_core_st_t q, d;

    // ==================================================
    // Core configuration decode
    always_comb begin
        d = q;
        case (cfg.mode_code)
            3'h0:    d.mode = DDC_SINGLE;
            3'h1:    d.mode = DDC_FSK;                     // [R14]
            3'h2:    d.mode = DDC_RAMP;
            3'h3:    d.mode = DDC_CHIRP;
            3'h4:    d.mode = DDC_BPSK;
            default: d.mode = DDC_SINGLE;                  // [R17]
        endcase
        // Out-of-range ratios clamp so the loop never sees an illegal divider
        if (cfg.mult < MULT_MIN)      d.mult = MULT_MIN;   // [R7]
        else if (cfg.mult > MULT_MAX) d.mult = MULT_MAX;
        else                          d.mult = cfg.mult;
        // Converter sample is refreshed every cycle from the selected source
        d.qd    = cfg.aux_src ? cfg.aux_data : q_path_data_i; // [R1] [R3]
        d.pd    = cfg.q_pd;                                // [R4]
        d.isb   = cfg.sinc_byp;                            // [R6]
        d.qsb   = cfg.sinc_byp | cfg.aux_src;              // [R5] [R6]
        d.range = cfg.pll_range;
        d.byp   = cfg.pll_bypass;                          // [R8]
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '{mode: DDC_SINGLE, mult: MULT_MIN, qd: 12'h000, pd: 1'b0, isb: 1'b0,
                   qsb: 1'b0, range: 1'b0, byp: 1'b0};   // [R15]
        end else begin
            q <= d;
        end
    end

    assign q_dac_data_o      = q.qd;
    assign q_dac_pd_o        = q.pd;
    assign i_sinc_bypass_o   = q.isb;
    assign q_sinc_bypass_o   = q.qsb;
    assign ref_mult_o        = q.mult;
    assign pll_range_o       = q.range;
    assign sysclk_from_ref_o = q.byp;
    assign mode_o            = q.mode;

    // ==================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_aux_src;
        cfg.aux_src |=> q_dac_data_o == $past(cfg.aux_data);
    endproperty
    a_aux_src: assert property (p_aux_src) else $error("aux data not on converter"); // [R1]

    property p_int_src;
        !cfg.aux_src ##1 !cfg.aux_src |-> q_dac_data_o == $past(q_path_data_i);
    endproperty
    a_int_src: assert property (p_int_src) else $error("internal data not on converter"); // [R3]

    property p_aux_nosinc;
        cfg.aux_src |=> q_sinc_bypass_o && (i_sinc_bypass_o == $past(cfg.sinc_byp));
    endproperty
    a_aux_nosinc: assert property (p_aux_nosinc) else $error("aux data went through sinc"); // [R5]

    property p_sinc_byp;
        cfg.sinc_byp |=> i_sinc_bypass_o && q_sinc_bypass_o;
    endproperty
    a_sinc_byp: assert property (p_sinc_byp) else $error("sinc bypass not applied"); // [R6]

    property p_qpd;
        $rose(cfg.q_pd) |=> q_dac_pd_o && (i_sinc_bypass_o == $past(cfg.sinc_byp));
    endproperty
    a_qpd: assert property (p_qpd) else $error("q converter not powered down"); // [R4]

    property p_mult;
        (cfg.mult >= MULT_MIN && cfg.mult <= MULT_MAX) |=> ref_mult_o == $past(cfg.mult);
    endproperty
    a_mult: assert property (p_mult) else $error("multiplier ratio wrong"); // [R7]

    property p_byp;
        cfg.pll_bypass == 1'b1 |=> sysclk_from_ref_o;
    endproperty
    a_byp: assert property (p_byp) else $error("system clock not from reference"); // [R8]

    property p_bad_mode;
        cfg.mode_code > 3'h4 |=> mode_o == DDC_SINGLE;
    endproperty
    a_bad_mode: assert property (p_bad_mode) else $error("undefined mode not single"); // [R17]

    property p_mode;
        cfg.mode_code <= 3'h4 |=> mode_o == $past(cfg.mode_code);
    endproperty
    a_mode: assert property (p_mode) else $error("mode code not followed"); // [R14]

    c_aux_mode: cover property (cfg.aux_src ##1 q_sinc_bypass_o);
endmodule : ddc_core

//--- src/ddc_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1 - Aux select feeds Q converter user data
// R2 - Host may update aux data via either port
// R3 - Converter sample taken every clock
// R4 - Power-down bit stops only Q converter
// R5 - Aux data never passes inverse sinc
// R6 - Sinc active after reset, bypass bit skips
// R7 - Five-bit ratio field, four to twenty
// R8 - Bypass bit clocks system from reference
// R9 - Host sets range bit per clock rate
// R10 - Differential pin picks differential reference
// R11 - Port pin high parallel, low serial
// R12 - Serial bit order set by control bit
// R13 - Readback pin select routes serial output
// R14 - Three-bit field selects operating mode
// R15 - Reset returns mode to single tone
// R16 - Writes buffered, applied on update edge
// R17 - Undefined mode codes behave as single tone
module ddc_top
    import ddc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        port_sel_i,
    input  wire logic        differential_ref_select_i,
    input  wire logic        update_clk_i,
    input  wire logic [5:0]  par_addr_i,
    input  wire logic [7:0]  par_data_i,
    input  wire logic        par_wr_n_i,
    input  wire logic        par_rd_n_i,
    output logic      [7:0]  par_data_o,
    output logic             par_data_oe_o,
    input  wire logic        ser_sclk_i,
    input  wire logic        ser_cs_n_i,
    input  wire logic        ser_sdio_i,
    output logic             ser_sdio_o,
    output logic             ser_sdio_oe_o,
    output logic             ser_sdo_o,
    input  wire logic [11:0] q_path_data_i,
    output logic      [11:0] q_dac_data_o,
    output logic             q_dac_pd_o,
    output logic             i_sinc_bypass_o,
    output logic             q_sinc_bypass_o,
    output logic      [4:0]  ref_mult_o,
    output logic             pll_range_o,
    output logic             sysclk_from_ref_o,
    output logic             ref_diff_en_o,
    output logic      [2:0]  mode_o
);
    typedef struct packed {
        logic [21:0] s1;
        logic [21:0] s2;
        logic [21:0] s3;
        logic [21:0] f;
        logic [7:0]  pd;
        logic [7:0]  clk;
        logic [7:0]  mode;
        logic [7:0]  filt;
        logic [11:0] aux;
        logic [7:0]  a_pd;
        logic [7:0]  a_clk;
        logic [7:0]  a_mode;
        logic [7:0]  a_filt;
        logic [11:0] a_aux;
        ddc_ser_st_t st;
        logic [2:0]  bcnt;
        logic [7:0]  sh;
        logic [7:0]  o;
        logic [5:0]  addr;
        logic        rd;
        logic        sdo;
        logic [7:0]  pdo;
        logic        pdo_oe;
    } ddc_top_st_t;

    ddc_top_st_t q, d;
    logic        psel;
    logic        wr_rise;
    logic        upd_rise;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        lsbf;
    logic        sdo_sel;
    logic [7:0]  nb;

    // ==================================================
    // Register access helpers
    function automatic logic [7:0] rd_reg(input ddc_top_st_t s, input logic [5:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_PD:     v = s.pd;
            ADDR_CLK:    v = s.clk;
            ADDR_MODE:   v = s.mode;
            ADDR_FILT:   v = s.filt;
            ADDR_AUX_HI: v = {4'h0, s.aux[11:8]};
            ADDR_AUX_LO: v = s.aux[7:0];
            default:     v = 8'h00;
        endcase
        return v;
    endfunction : rd_reg

    function automatic ddc_top_st_t wr_reg(input ddc_top_st_t s, input logic [5:0] a,
                                           input logic [7:0] v);
        ddc_top_st_t r;
        r = s;
        case (a)
            ADDR_PD:     r.pd        = v & PD_MASK;
            ADDR_CLK:    r.clk       = v & CLK_MASK;
            ADDR_MODE:   r.mode      = v & MODE_MASK;
            ADDR_FILT:   r.filt      = v & FILT_MASK;
            ADDR_AUX_HI: r.aux[11:8] = v[3:0];             // [R2]
            ADDR_AUX_LO: r.aux[7:0]  = v;                  // [R2]
            default:     r.pd        = s.pd;
        endcase
        return r;
    endfunction : wr_reg

    // ==================================================
    // Next-state logic
    always_comb begin
        d    = q;
        // Three-stage pin capture; a level counts once stages two and three agree
        d.s1 = {par_addr_i, par_data_i, par_wr_n_i, par_rd_n_i, ser_sclk_i, ser_cs_n_i,
                ser_sdio_i, port_sel_i, differential_ref_select_i, update_clk_i};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.f  = (q.s2 & q.s3) | (q.f & (q.s2 | q.s3));

        psel      = d.f[SY_PSEL];
        wr_rise   = d.f[SY_WR] & ~q.f[SY_WR];
        upd_rise  = d.f[SY_UPD] & ~q.f[SY_UPD];
        sclk_rise = d.f[SY_SCLK] & ~q.f[SY_SCLK];
        sclk_fall = ~d.f[SY_SCLK] & q.f[SY_SCLK];
        lsbf      = q.filt[FILT_LSBF_BIT];
        sdo_sel   = q.filt[FILT_SDO_BIT];
        nb        = lsbf ? {d.f[SY_SDIO], q.sh[7:1]} : {q.sh[6:0], d.f[SY_SDIO]}; // [R12]

        // Core copy takes the buffer as it stood before any write in this cycle
        if (upd_rise) begin                                // [R16]
            d.a_pd   = q.pd;
            d.a_clk  = q.clk;
            d.a_mode = q.mode;
            d.a_filt = q.filt;
            d.a_aux  = q.aux;
        end

        // Parallel port: write lands on the trailing edge of the strobe
        d.pdo    = rd_reg(q, d.f[SY_ADDR +: 6]);
        d.pdo_oe = psel & ~d.f[SY_RD];                     // [R11]
        if (psel && wr_rise) begin                         // [R11]
            d = wr_reg(d, d.f[SY_ADDR +: 6], d.f[SY_DATA +: 8]);
        end

        // Serial port: instruction byte (bit 7 read, bits 5:0 address), then data
        // bytes with auto-incrementing address
        if (psel || d.f[SY_CS]) begin                      // [R11]
            d.st   = SER_IDLE;
            d.bcnt = 3'h0;
            d.rd   = 1'b0;
        end else begin
            if (q.st == SER_IDLE) begin
                d.st = SER_INSTR;
            end
            if (sclk_rise) begin
                d.sh   = nb;
                d.bcnt = q.bcnt + 3'h1;
                if (q.bcnt == BIT_LAST) begin
                    case (q.st)
                        SER_IDLE, SER_INSTR: begin
                            d.rd   = nb[7];
                            d.addr = nb[5:0];
                            d.o    = rd_reg(q, nb[5:0]);
                            d.st   = SER_DATA;
                        end
                        SER_DATA: begin
                            if (!q.rd) begin
                                d = wr_reg(d, q.addr, nb);
                            end
                            d.addr = q.addr + 6'h1;
                            d.o    = rd_reg(q, q.addr + 6'h1);
                        end
                        default: d.st = SER_IDLE;
                    endcase
                end
            end
            // Read data changes on the falling edge so the host samples on the rising one
            if (sclk_fall && q.st == SER_DATA && q.rd) begin
                d.sdo = lsbf ? q.o[0] : q.o[7];            // [R12]
                d.o   = lsbf ? {1'b0, q.o[7:1]} : {q.o[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q        <= '0;
            q.s1     <= SYNC_RST;
            q.s2     <= SYNC_RST;
            q.s3     <= SYNC_RST;
            q.f      <= SYNC_RST;
            q.pd     <= RST_PD;
            q.clk    <= RST_CLK;
            q.mode   <= RST_MODE;                          // [R15]
            q.filt   <= RST_FILT;                          // [R6]
            q.aux    <= RST_AUX;
            q.a_pd   <= RST_PD;
            q.a_clk  <= RST_CLK;
            q.a_mode <= RST_MODE;                          // [R15]
            q.a_filt <= RST_FILT;
            q.a_aux  <= RST_AUX;
            q.st     <= SER_IDLE;
        end else begin
            q <= d;
        end
    end

    // ==================================================
    // Pin outputs
    assign par_data_o    = q.pdo;
    assign par_data_oe_o = q.pdo_oe;
    assign ser_sdio_o    = q.sdo;
    // Shared data pin turns round only when no dedicated readback pin is chosen
    assign ser_sdio_oe_o = ~q.f[SY_PSEL] & ~q.f[SY_CS] & (q.st == SER_DATA) & q.rd
                           & ~sdo_sel;                     // [R13]
    assign ser_sdo_o     = sdo_sel & q.sdo;                // [R13]
    assign ref_diff_en_o = q.f[SY_DIFF];                   // [R10]

    // ==================================================
    // Active configuration to the core
    ddc_cfg_if cfg ();

    assign cfg.q_pd       = q.a_pd[PD_QDAC_BIT];
    assign cfg.pll_range  = q.a_clk[CLK_RANGE_BIT];
    assign cfg.pll_bypass = q.a_clk[CLK_BYP_BIT];
    assign cfg.mult       = q.a_clk[4:0];
    assign cfg.mode_code  = q.a_mode[MODE_LSB +: 3];
    assign cfg.aux_src    = q.a_mode[MODE_SRC_BIT];
    assign cfg.sinc_byp   = q.a_filt[FILT_SINC_BIT];
    assign cfg.aux_data   = q.a_aux;

    ddc_core u_core (
        .clk_i             (clk_i),
        .sys_rst_i         (sys_rst_i),
        .cfg               (cfg),
        .q_path_data_i     (q_path_data_i),
        .q_dac_data_o      (q_dac_data_o),
        .q_dac_pd_o        (q_dac_pd_o),
        .i_sinc_bypass_o   (i_sinc_bypass_o),
        .q_sinc_bypass_o   (q_sinc_bypass_o),
        .ref_mult_o        (ref_mult_o),
        .pll_range_o       (pll_range_o),
        .sysclk_from_ref_o (sysclk_from_ref_o),
        .mode_o            (mode_o)
    );

    // ==================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_par_wr;
        (psel && wr_rise && d.f[SY_ADDR +: 6] == ADDR_AUX_LO) |=> q.aux[7:0] == $past(d.f[15:8]);
    endproperty
    a_par_wr: assert property (p_par_wr) else $error("parallel aux write lost"); // [R2]

    property p_ser_quiet;
        !q.f[SY_PSEL] |-> !par_data_oe_o;
    endproperty
    a_ser_quiet: assert property (p_ser_quiet) else $error("parallel bus driven in serial"); // [R11]

    property p_par_quiet;
        q.f[SY_PSEL] |-> !ser_sdio_oe_o && q.st == SER_IDLE;
    endproperty
    a_par_quiet: assert property (p_par_quiet) else $error("serial active in parallel"); // [R11]

    property p_sdo_pin;
        sdo_sel |-> !ser_sdio_oe_o;
    endproperty
    a_sdo_pin: assert property (p_sdo_pin) else $error("sdio driven with sdo selected"); // [R13]

    property p_sdo_idle;
        !sdo_sel |-> !ser_sdo_o;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo pin used while unselected"); // [R13]

    property p_lsbf;
        (sclk_fall && q.st == SER_DATA && q.rd && !d.f[SY_CS] && !psel)
            |=> ser_sdio_o == ($past(lsbf) ? $past(q.o[0]) : $past(q.o[7]));
    endproperty
    a_lsbf: assert property (p_lsbf) else $error("serial bit order wrong"); // [R12]

    property p_update;
        upd_rise |=> q.a_mode == $past(q.mode) && q.a_aux == $past(q.aux);
    endproperty
    a_update: assert property (p_update) else $error("update did not copy buffer"); // [R16]

    property p_hold;
        !upd_rise |=> $stable(q.a_mode) && $stable(q.a_filt) && $stable(q.a_clk);
    endproperty
    a_hold: assert property (p_hold) else $error("core changed without update"); // [R16]

    property p_diff;
        differential_ref_select_i [*4] |=> ref_diff_en_o;
    endproperty
    a_diff: assert property (p_diff) else $error("differential select not followed"); // [R10]

    c_par_wr: cover property (psel && wr_rise ##[1:20] upd_rise);
    c_ser_rd: cover property (q.st == SER_DATA && q.rd && sclk_fall);
    c_ser_wr: cover property (q.st == SER_DATA && !q.rd && sclk_rise && q.bcnt == BIT_LAST);
endmodule : ddc_top

//--- dv/ddc_host_model.sv
`timescale 1ns/10ps
module ddc_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       sdio_i,
    output logic            port_sel_o,
    output logic            upd_o,
    output logic [5:0]      addr_o,
    output logic [7:0]      data_o,
    output logic            wr_n_o,
    output logic            rd_n_o,
    output logic            sclk_o,
    output logic            cs_n_o,
    output logic            sdio_o
);
    // ==================================================
    // Pins move on falling edges only; each phase spans at least 5 clocks, above the 4-clock filter
    initial begin
        {port_sel_o, wr_n_o, rd_n_o, cs_n_o} = 4'hf;
        {upd_o, sclk_o, sdio_o} = 3'h0;
        addr_o = 6'h00;
        data_o = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        tick(1);
        addr_o = a;
        data_o = d;
        wr_n_o = 1'b0;
        tick(6);
        wr_n_o = 1'b1;
        tick(6);
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        tick(1);
        addr_o = a;
        rd_n_o = 1'b0;
        tick(8);
        d = rdata_i;
        rd_n_o = 1'b1;
        tick(6);
    endtask : rd
    task automatic upd;
        tick(1);
        upd_o = 1'b1;
        tick(6);
        upd_o = 1'b0;
        tick(8);
    endtask : upd
    // Top bit always goes out first; callers bit-reverse words for low-bit-first order
    task automatic sbyte(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            sclk_o = 1'b0;
            sdio_o = b[i];
            tick(5);
            // Read data settled after the previous falling edge
            r[i]   = sdio_i;
            sclk_o = 1'b1;
            tick(5);
        end
    endtask : sbyte
    task automatic swr(input logic [7:0] ins, d, output logic [7:0] r);
        logic [7:0] x;
        tick(1);
        port_sel_o = 1'b0;
        tick(6);
        cs_n_o = 1'b0;
        tick(5);
        sbyte(ins, x);
        sbyte(d, r);
        sclk_o = 1'b0;
        tick(5);
        cs_n_o = 1'b1;
        sdio_o = ~sdio_o;
        tick(5);
        port_sel_o = 1'b1;
        tick(6);
    endtask : swr
endmodule : ddc_host_model

//--- dv/dds_config_control_tb.sv
`timescale 1ns/10ps
module dds_config_control_tb
    import ddc_pkg::*;
;
    logic        clk, rst, psel, upd, wr_n, rd_n, sclk, cs_n, h_sdio, sd_o, sd_oe, diff;
    logic        qpd, isb, qsb, rng, byp, dfe, sdo, poe;
    logic [5:0]  addr;
    logic [7:0]  wd, rdat, rv;
    logic [11:0] qpath, qdac;
    logic [4:0]  mult;
    logic [2:0]  mode;
    int          miscompares, checks_done, cyc;
    // Shared data line: the design wins while it drives
    wire         sdio = sd_oe ? sd_o : h_sdio;

    ddc_top i_ddc_top (.clk_i(clk), .sys_rst_i(rst), .port_sel_i(psel),
        .differential_ref_select_i(diff), .update_clk_i(upd), .par_addr_i(addr),
        .par_data_i(wd), .par_wr_n_i(wr_n), .par_rd_n_i(rd_n), .par_data_o(rdat),
        .par_data_oe_o(poe), .ser_sclk_i(sclk), .ser_cs_n_i(cs_n), .ser_sdio_i(sdio),
        .ser_sdio_o(sd_o), .ser_sdio_oe_o(sd_oe), .ser_sdo_o(sdo), .q_path_data_i(qpath),
        .q_dac_data_o(qdac), .q_dac_pd_o(qpd), .i_sinc_bypass_o(isb),
        .q_sinc_bypass_o(qsb), .ref_mult_o(mult), .pll_range_o(rng),
        .sysclk_from_ref_o(byp), .ref_diff_en_o(dfe), .mode_o(mode));
    ddc_host_model i_ddc_host_model (.clk_i(clk), .rdata_i(rdat), .port_sel_o(psel),
        .upd_o(upd), .addr_o(addr), .data_o(wd), .wr_n_o(wr_n), .rd_n_o(rd_n),
        .sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(h_sdio), .sdio_i(sd_oe ? sd_o : sdo));

    // ==================================================
    // Clock, checking and closing
    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic close_out;
        if (miscompares == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    // ==================================================
    // Scenarios
    task automatic t_reset;
        chk("mode", mode, 12'h000);
        chk("mult", mult, 12'h004);
        chk("sinc", {isb, qsb}, 12'h000);
        chk("qpd", qpd, 12'h000);
        chk("byp", byp, 12'h000);
        chk("qdac", qdac, qpath);
        chk("poe", poe, 12'h000);
        i_ddc_host_model.rd(ADDR_CLK, rv);
        chk("rd_clk", rv, RST_CLK);
    endtask : t_reset
    task automatic t_mode;
        logic [2:0] prev;
        prev = 3'h0;
        for (int m = 0; m < 8; m++) begin
            i_ddc_host_model.wr(ADDR_MODE, 8'(m << 1));
            chk("mode_held", mode, prev);
            i_ddc_host_model.upd();
            prev = (m > 4) ? 3'h0 : 3'(m);
            chk("mode", mode, prev);
        end
    endtask : t_mode
    task automatic t_mult;
        logic [7:0] v [5];
        logic [4:0] e;
        v = '{8'h03, 8'h24, 8'h4d, 8'h14, 8'h7f};
        foreach (v[k]) begin
            // Range bit (bit 6) set only in 8'h4d and 8'h7f, independent of the ratio field
            i_ddc_host_model.wr(ADDR_CLK, v[k]);
            i_ddc_host_model.upd();
            e = (v[k][4:0] < 5'h04) ? 5'h04 : (v[k][4:0] > 5'h14) ? 5'h14 : v[k][4:0];
            chk("mult", mult, e);
            chk("byp", byp, v[k][5]);
            chk("rng", rng, v[k][6]);
            i_ddc_host_model.rd(ADDR_CLK, rv);
            chk("rd_clk", rv, v[k] & CLK_MASK);
        end
    endtask : t_mult
    task automatic t_aux;
        qpath = 12'h1c7;
        i_ddc_host_model.wr(ADDR_AUX_HI, 8'h0b);
        i_ddc_host_model.wr(ADDR_AUX_LO, 8'hcd);
        i_ddc_host_model.wr(ADDR_MODE, 8'h10);
        i_ddc_host_model.upd();
        chk("qdac", qdac, 12'hbcd);
        chk("qsb", qsb, 12'h001);
        chk("isb", isb, 12'h000);
        i_ddc_host_model.swr({2'b00, ADDR_AUX_LO}, 8'h21, rv);
        i_ddc_host_model.upd();
        chk("qdac_ser", qdac, 12'hb21);
        i_ddc_host_model.swr({2'b10, ADDR_AUX_LO}, 8'h00, rv);
        chk("srd", rv, 12'h021);
        i_ddc_host_model.wr(ADDR_MODE, 8'h00);
        i_ddc_host_model.upd();
        chk("qdac", qdac, 12'h1c7);
    endtask : t_aux
    // Low-bit-first words are passed bit-reversed; the read returns on the readback pin
    task automatic t_serial;
        i_ddc_host_model.wr(ADDR_FILT, 8'h03);
        i_ddc_host_model.swr(8'he4, 8'h7a, rv);
        i_ddc_host_model.swr(8'he5, 8'h00, rv);
        chk("srd_lsbf", rv, 12'h07a);
        i_ddc_host_model.rd(ADDR_AUX_LO, rv);
        chk("rd_aux", rv, 12'h05e);
        i_ddc_host_model.wr(ADDR_FILT, 8'h00);
    endtask : t_serial
    task automatic t_pd_sinc;
        i_ddc_host_model.wr(ADDR_PD, PD_MASK);
        i_ddc_host_model.wr(ADDR_FILT, 8'h40);
        i_ddc_host_model.upd();
        chk("qpd", qpd, 12'h001);
        chk("sinc", {isb, qsb}, 12'h003);
        chk("qdac", qdac, 12'h1c7);
        i_ddc_host_model.rd(6'h00, rv);
        chk("rd_unmapped", rv, 12'h000);
        i_ddc_host_model.rd(ADDR_FILT, rv);
        chk("rd_filt", rv, 12'h040);
        i_ddc_host_model.wr(ADDR_PD, 8'h00);
        i_ddc_host_model.wr(ADDR_FILT, 8'h00);
        i_ddc_host_model.upd();
        chk("sinc_pd", {isb, qsb, qpd}, 12'h000);
    endtask : t_pd_sinc
    task automatic t_diff;
        diff = 1'b1;
        i_ddc_host_model.tick(8);
        chk("diff", dfe, 12'h001);
        diff = 1'b0;
        i_ddc_host_model.tick(8);
        chk("diff", dfe, 12'h000);
    endtask : t_diff

    initial begin
        rst = 1'b1;
        diff = 1'b0;
        qpath = 12'h5a3;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        i_ddc_host_model.tick(6);
        t_reset();
        t_mode();
        t_mult();
        t_aux();
        t_serial();
        t_pd_sinc();
        t_diff();
        close_out();
    end
endmodule : dds_config_control_tb
